// ---- bench/fcpm_pins.sv ----
// Purpose: Board side of the shared pins.
// Assumes: An outside source drives any pin the block releases.
// Notes: The outside level is chosen so a stale driven value is visible.
`timescale 1ns/1ps
`default_nettype none
module fcpm_pins (
   input wire logic [3:0] pin_o_i,
   input wire logic [3:0] pin_oe_i,
   input wire logic [3:0] ext_i,
   output logic [3:0] pin_i_o
);
   // Each wire shows the block's value only while the block drives it.
   assign pin_i_o = (pin_o_i & pin_oe_i) | (ext_i & ~pin_oe_i);
endmodule : fcpm_pins
`default_nettype wire

// ---- bench/fcpm_top_props.sv ----
// Purpose: Concurrent checks on the bus handshake and pin ownership.
// Assumes: Writes are tracked at the ack edge.
// Notes: Pin checks run only while the bus is idle, where writes have settled.
`timescale 1ns/1ps
`default_nettype none
module fcpm_top_props #(
   parameter int PRE_BITS = 7
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic [3:0] pin_i,
   input wire logic [3:0] pin_o,
   input wire logic [3:0] pin_oe_o,
   input wire logic ack_o
);
   logic [3:0] en_q, dir_q, out_q;
   logic [1:0] con_q;
   // The block writes at the edge that raises ack; the shadow takes the write at the later edge where ack is seen.
   wire wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];
   wire idle = !(cyc_i || stb_i);
   wire [3:0] en_eff = {en_q[3] & ~con_q[1], en_q[2], en_q[1] & ~con_q[0], en_q[0]};
   // Shadow of enables, pairing and port registers.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {en_q, dir_q, out_q, con_q} <= '0;
      end else if (wr) begin
         if (adr_i == fcpm_pkg::OFS_CTRL) {con_q, en_q} <= {dat_i[13:12], dat_i[3:0]};
         if (adr_i == fcpm_pkg::OFS_PORT_DIR) dir_q <= dat_i[3:0];
         if (adr_i == fcpm_pkg::OFS_PORT_OUT) out_q <= dat_i[3:0];
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_rd_done;
      ack_o && !we_i ##1 !(cyc_i && stb_i);
   endsequence
   a_ack_follows_req: assert property (s_req |=> ack_o)
      else $error("ack missing after request");
   a_ack_single_cycle: assert property (ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");
   a_ack_has_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   a_read_data_holds: assert property (s_rd_done |-> $stable(dat_o))
      else $error("read data changed after ack");
   a_unmapped_reads_zero: assert property (s_req and (!we_i && adr_i >= 8'h50)
      |=> dat_o == fcpm_pkg::READ_UNMAPPED)
      else $error("unmapped read not zero");
   a_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && pin_oe_o == 4'h0)
      else $error("outputs active after reset");
   a_pin_owner: assert property (idle |-> pin_oe_o == (en_eff | dir_q))
      else $error("pin direction wrong");
   a_port_value: assert property (idle |-> ((pin_o ^ out_q) & dir_q & ~en_eff) == 4'h0)
      else $error("port value not on pin");
endmodule : fcpm_top_props
bind fcpm_top fcpm_top_props #(.PRE_BITS(PRE_BITS)) u_props (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .pin_i(pin_i),
   .pin_o(pin_o), .pin_oe_o(pin_oe_o), .ack_o(ack_o));
`default_nettype wire

// ---- bench/fcpm_top_tb.sv ----
// Purpose: Register-driven tests of the pulse modulator.
// Assumes: Prescale code 0 gives one counter tick per clock.
// Notes: High times are counted over whole periods, so phase does not matter, except in the buffer test's 20-clock windows of a 200-clock period.
`timescale 1ns/1ps
`default_nettype none
module fcpm_top_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'hF;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o, rd, rd2;
   logic ack_o;
   logic [3:0] pin_i, pin_o, pin_oe_o;
   logic [3:0] ext = 4'hA;
   int num_errors = 0;
   int checked = 0;
   int pin_sel = 0;
   int duty[3] = '{4, 0, 10};
   int high[3] = '{8, 0, 20};
   always #10 clk_i = ~clk_i;
   fcpm_top #(.PRE_BITS(7)) DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o));
   fcpm_pins PINS (.pin_o_i(pin_o), .pin_oe_i(pin_oe_o), .ext_i(ext), .pin_i_o(pin_i));
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // One classic cycle; the request holds until ack is sampled high.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 40);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      if (n >= 40) begin
         num_errors++;
         conclude();
      end
      @(posedge clk_i);
   endtask : wb
   // Counts clocks with the pin selected by pin_sel high.
   task automatic hi(input int n, input int exp);
      int c;
      c = 0;
      repeat (n) begin
         @(posedge clk_i);
         c = c + int'(pin_o[pin_sel] === 1'b1);
      end
      chk(32'(c), 32'(exp));
   endtask : hi
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk(32'(pin_oe_o), 32'h0);
      for (int k = 0; k < 5; k++) begin
         wb(1'b0, 8'(k < 2 ? k * 4 : k * 16), 32'h0);
         chk(rd, 32'h0);
      end
      wb(1'b0, 8'hFC, 32'h0);
      chk(rd, fcpm_pkg::READ_UNMAPPED);
      $display("test reset done");
      wb(1'b1, fcpm_pkg::OFS_PORT_DIR, 32'h4);
      wb(1'b1, fcpm_pkg::OFS_PORT_OUT, 32'h7);
      chk(32'(pin_oe_o), 32'h4);
      wb(1'b0, fcpm_pkg::OFS_PIN, 32'h0);
      chk(rd & 32'hF, 32'hE);
      $display("test port done");
      wb(1'b1, fcpm_pkg::OFS_CNT0, 32'h0);
      wb(1'b1, fcpm_pkg::OFS_PER0, 32'd10);
      wb(1'b1, fcpm_pkg::OFS_DUTY0, 32'd4);
      wb(1'b0, fcpm_pkg::OFS_PER0, 32'h0);
      chk(rd, 32'd10);
      wb(1'b1, fcpm_pkg::OFS_CTRL, 32'h11);
      chk(32'(pin_oe_o), 32'h5);
      for (int i = 0; i < 3; i++) begin
         wb(1'b1, fcpm_pkg::OFS_DUTY0, 32'(duty[i]));
         wb(1'b1, fcpm_pkg::OFS_CNT0, 32'h0);
         hi(20, high[i]);
      end
      $display("test duty done");
      wb(1'b1, fcpm_pkg::OFS_PER0, 32'd200);
      wb(1'b1, fcpm_pkg::OFS_DUTY0, 32'd100);
      wb(1'b1, fcpm_pkg::OFS_CNT0, 32'h0);
      wb(1'b1, fcpm_pkg::OFS_DUTY0, 32'd0);
      hi(20, 20);
      repeat (200) @(posedge clk_i);
      hi(20, 0);
      wb(1'b1, fcpm_pkg::OFS_PER0, 32'd10);
      wb(1'b1, fcpm_pkg::OFS_DUTY0, 32'd4);
      wb(1'b1, fcpm_pkg::OFS_CNT0, 32'h0);
      $display("test buffer done");
      wb(1'b1, fcpm_pkg::OFS_CTRL, 32'h01);
      hi(20, 12);
      wb(1'b1, fcpm_pkg::OFS_CTRL, 32'h11);
      for (int c = 0; c < 8; c++) begin
         wb(1'b1, fcpm_pkg::OFS_CLK, 32'(c << fcpm_pkg::F_PRE_A));
         wb(1'b1, fcpm_pkg::OFS_CNT0, 32'h0);
         hi(20 << c, 8 << c);
      end
      // Scaled clock S0 with scale 1 gives one tick every four clocks.
      wb(1'b1, fcpm_pkg::OFS_SCAL, 32'h1);
      wb(1'b1, fcpm_pkg::OFS_CLK, 32'h1);
      wb(1'b1, fcpm_pkg::OFS_CNT0, 32'h0);
      hi(80, 32);
      wb(1'b1, fcpm_pkg::OFS_CLK, 32'h0);
      $display("test prescale done");
      // Centre mode runs 0 up to 9 and back to 1: 18 states, 7 below duty.
      wb(1'b1, fcpm_pkg::OFS_CTRL, 32'h111);
      wb(1'b1, fcpm_pkg::OFS_CNT0, 32'h0);
      hi(36, 14);
      $display("test center done");
      wb(1'b1, fcpm_pkg::OFS_CTRL, 32'h10);
      wb(1'b0, fcpm_pkg::OFS_CNT0, 32'h0);
      rd2 = rd;
      chk(32'(rd2 < 10), 32'h1);
      wb(1'b0, fcpm_pkg::OFS_CNT0, 32'h0);
      chk(rd, rd2);
      wb(1'b1, fcpm_pkg::OFS_CNT0, 32'h0);
      wb(1'b0, fcpm_pkg::OFS_CNT0, 32'h0);
      chk(rd, 32'h0);
      $display("test counter done");
      // Channel 2 on clock B at code 1 takes pin 2 away from the port.
      wb(1'b1, fcpm_pkg::OFS_PER0 + 8'h08, 32'd8);
      wb(1'b1, fcpm_pkg::OFS_DUTY0 + 8'h08, 32'd2);
      wb(1'b1, fcpm_pkg::OFS_CNT0 + 8'h08, 32'h0);
      wb(1'b1, fcpm_pkg::OFS_CLK, 32'(1 << fcpm_pkg::F_PRE_B));
      wb(1'b1, fcpm_pkg::OFS_CTRL, 32'h44);
      chk(32'(pin_oe_o), 32'h4);
      pin_sel = 2;
      hi(32, 8);
      pin_sel = 0;
      wb(1'b1, fcpm_pkg::OFS_CLK, 32'h0);
      $display("test channel two done");
      wb(1'b1, fcpm_pkg::OFS_PER0, 32'h0);
      wb(1'b1, fcpm_pkg::OFS_PER0 + 8'h04, 32'd20);
      wb(1'b1, fcpm_pkg::OFS_DUTY0, 32'h0);
      wb(1'b1, fcpm_pkg::OFS_DUTY0 + 8'h04, 32'd5);
      wb(1'b1, fcpm_pkg::OFS_CNT0, 32'h0);
      wb(1'b1, fcpm_pkg::OFS_CTRL, 32'h1013);
      chk(32'(pin_oe_o), 32'h5);
      hi(40, 10);
      $display("test pair done");
      conclude();
   end
   // Hard limit on run length.
   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      conclude();
   end
endmodule : fcpm_top_tb
`default_nettype wire

// ---- hdl/fcpm_chan.sv ----
// Purpose: One waveform channel: counter, buffered period and duty.
// Assumes: tick_i is a one-cycle enable from the selected clock.
// Notes: Used at 16 bits both for an 8-bit channel and for a joined pair.
`timescale 1ns/1ps
`default_nettype none
module fcpm_chan #(
   parameter int W = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   input wire logic pol_i,
   input wire logic center_i,
   input wire logic tick_i,
   input wire logic [W-1:0] per_buf_i,
   input wire logic [W-1:0] duty_buf_i,
   input wire logic cnt_wr_i,
   output logic [W-1:0] cnt_o,
   output logic [W-1:0] per_o,
   output logic [W-1:0] duty_o,
   output logic wave_o
);
   logic down;
   logic at_end;
   logic rollover;
   logic on_raw;

   assign at_end = (cnt_o + 1'b1 >= per_o) || per_o == '0;
   // Left mode rolls at period; centre mode turns at period and at zero.
   assign rollover = center_i ? (down && cnt_o <= {{(W-1){1'b0}}, 1'b1}) : at_end;
   // Output asserts for count below duty; duty >= a nonzero period gives fully on.
   assign on_raw = cnt_o < duty_o || duty_o >= per_o && per_o != '0;
   // Polarity one starts high, zero starts low and rises at duty.
   assign wave_o = en_i && (pol_i ? on_raw : !on_raw);

   // Counter; disabling never clears it, only a write or reset does.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_o <= '0;
         down <= 1'b0;
      end else if (cnt_wr_i) begin
         cnt_o <= '0;
         down <= 1'b0;
      end else if (en_i && tick_i) begin
         if (center_i) begin
            if (!down && at_end) down <= 1'b1;
            else if (down && rollover) down <= 1'b0;
            cnt_o <= (!down && !at_end) ? cnt_o + 1'b1 : (cnt_o == '0 ? '0 : cnt_o - 1'b1);
         end else begin
            cnt_o <= at_end ? '0 : cnt_o + 1'b1;
         end
      end
   end

   // Active latches load from the buffer at rollover, when off, or on
   // a counter write, so a pair written between two rollovers reaches the pin whole.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         per_o <= '0;
         duty_o <= '0;
      end else if (!en_i || cnt_wr_i || (tick_i && rollover)) begin
         per_o <= per_buf_i;
         duty_o <= duty_buf_i;
      end
   end
endmodule : fcpm_chan
`default_nettype wire

// ---- hdl/fcpm_clkgen.sv ----
// Purpose: Prescaler and scaler enables for clocks A, B, S0, S1.
// Assumes: One system clock; every slower rate is a one-cycle enable.
// Notes: Prescaler stops while no channel is enabled, to save power.
`timescale 1ns/1ps
`default_nettype none
module fcpm_clkgen #(
   parameter int PRE_BITS = 7
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic [2:0] pre_a_i,
   input wire logic [2:0] pre_b_i,
   input wire logic [7:0] scal0_i,
   input wire logic [7:0] scal1_i,
   input wire logic scal0_load_i,
   input wire logic scal1_load_i,
   output logic tick_a_o,
   output logic tick_b_o,
   output logic tick_s0_o,
   output logic tick_s1_o
);
   logic [PRE_BITS-1:0] pre;
   logic [7:0] sc0;
   logic [7:0] sc1;
   logic half0;
   logic half1;
   logic [PRE_BITS:0] pre_ext;

   // Divide by two to the code: a tick when the low code bits of the
   // incremented prescaler all read zero.
   function automatic logic pre_tick(input logic [PRE_BITS:0] v, input logic [2:0] code);
      logic [PRE_BITS:0] m;
      m = ({{PRE_BITS{1'b0}}, 1'b1} << code) - 1'b1;
      pre_tick = (v & m) == '0;
   endfunction : pre_tick

   assign pre_ext = {1'b0, pre} + 1'b1;
   assign tick_a_o = run_i && pre_tick(pre_ext, pre_a_i);
   assign tick_b_o = run_i && pre_tick(pre_ext, pre_b_i);
   assign tick_s0_o = tick_a_o && sc0 == 8'h00 && half0;
   assign tick_s1_o = tick_b_o && sc1 == 8'h00 && half1;

   // Free-running prescaler, cleared to zero while all channels are off.
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         pre <= '0;
      end else begin
         pre <= pre_ext[PRE_BITS-1:0];
      end
   end

   // Scaled clocks divide by (scale + 1) and then by two.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sc0 <= 8'h00;
         half0 <= 1'b0;
      end else if (scal0_load_i) begin
         sc0 <= scal0_i;
         half0 <= 1'b0;
      end else if (tick_a_o) begin
         sc0 <= (sc0 == 8'h00) ? scal0_i : sc0 - 8'h01;
         if (sc0 == 8'h00) half0 <= !half0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sc1 <= 8'h00;
         half1 <= 1'b0;
      end else if (scal1_load_i) begin
         sc1 <= scal1_i;
         half1 <= 1'b0;
      end else if (tick_b_o) begin
         sc1 <= (sc1 == 8'h00) ? scal1_i : sc1 - 8'h01;
         if (sc1 == 8'h00) half1 <= !half1;
      end
   end
endmodule : fcpm_clkgen
`default_nettype wire

// ---- hdl/fcpm_pkg.sv ----
// Purpose: Shared constants for the four channel pulse modulator.
// Assumes: Wishbone classic slave, 32-bit data, byte addresses.
// Notes: All register offsets are byte addresses of aligned words.
package fcpm_pkg;
   localparam int NCH = 4;
   localparam int AW = 8;
   // Register byte offsets.
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CLK = 8'h04;
   localparam logic [7:0] OFS_SCAL = 8'h08;
   localparam logic [7:0] OFS_PORT_OUT = 8'h0C;
   localparam logic [7:0] OFS_PORT_DIR = 8'h10;
   localparam logic [7:0] OFS_PIN = 8'h14;
   localparam logic [7:0] OFS_CNT0 = 8'h20;
   localparam logic [7:0] OFS_PER0 = 8'h30;
   localparam logic [7:0] OFS_DUTY0 = 8'h40;
   localparam logic [7:0] OFS_STRIDE = 8'h04;
   // Control register fields.
   localparam int F_EN = 0;
   localparam int F_POL = 4;
   localparam int F_CENTER = 8;
   localparam int F_CON_LO = 12;
   localparam int F_CON_HI = 13;
   // Clock register fields.
   localparam int F_CSEL = 0;
   localparam int F_PRE_A = 4;
   localparam int F_PRE_B = 8;
   localparam int PRE_W = 3;
   // Scaler register fields.
   localparam int F_SCAL0 = 0;
   localparam int F_SCAL1 = 8;
   localparam logic [7:0] CNT_RESET = 8'h00;
   localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
endpackage : fcpm_pkg

// ---- hdl/fcpm_top.sv ----
// Purpose: Four channel pulse modulator with a Wishbone register slave.
// Assumes: Classic Wishbone, 32-bit data, one-cycle registered ack.
// Notes: Channels may pair into 16-bit waveforms; pins are shared with
// a general-purpose port that the modulator outranks when enabled.
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fcpm_top #(
   parameter int PRE_BITS = 7
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic [3:0] pin_i,
   output logic [3:0] pin_o,
   output logic [3:0] pin_oe_o
);
   localparam int N = fcpm_pkg::NCH;
   logic [15:0] ctrl;
   logic [11:0] clkcfg;
   logic [15:0] scal;
   logic [3:0] port_out;
   logic [3:0] port_dir;
   logic [7:0] per_buf [N];
   logic [7:0] duty_buf [N];
   logic [N-1:0] cnt_wr;
   logic [N-1:0] wave;
   logic [15:0] cnt16 [N];
   logic [15:0] per16 [N];
   logic [15:0] duty16 [N];
   logic tick_a;
   logic tick_b;
   logic tick_s0;
   logic tick_s1;
   logic [N-1:0] tick_sel;
   logic req;
   logic wr;
   logic [31:0] next_dat;
   logic [3:0] en;
   logic [3:0] pol;
   logic [3:0] center;
   logic [3:0] csel;
   logic con_lo;
   logic con_hi;
   logic [3:0] chan_on;
   logic [3:0] pin_drive;

   // Byte-enable merge for partial writes.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      for (int i = 0; i < 4; i++) begin
         old[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
      merge = old;
   endfunction : merge

   // Decode of a register index within a four-entry bank.
   function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
      in_bank = a >= base && a < base + 8'h10 && a[1:0] == 2'b00;
   endfunction : in_bank

   assign req = cyc_i && stb_i && !ack_o;
   assign wr = req && we_i;
   assign en = ctrl[fcpm_pkg::F_EN +: 4];
   assign pol = ctrl[fcpm_pkg::F_POL +: 4];
   assign center = ctrl[fcpm_pkg::F_CENTER +: 4];
   assign con_lo = ctrl[fcpm_pkg::F_CON_LO];
   assign con_hi = ctrl[fcpm_pkg::F_CON_HI];
   assign csel = clkcfg[fcpm_pkg::F_CSEL +: 4];

   // Per-channel clock choice: channels 0,1 use A or S0, 2,3 use B or S1.
   assign tick_sel[0] = csel[0] ? tick_s0 : tick_a;
   assign tick_sel[1] = csel[1] ? tick_s0 : tick_a;
   assign tick_sel[2] = csel[2] ? tick_s1 : tick_b;
   assign tick_sel[3] = csel[3] ? tick_s1 : tick_b;

   fcpm_clkgen #(.PRE_BITS(PRE_BITS)) u_clk (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(|en),
      .pre_a_i(clkcfg[fcpm_pkg::F_PRE_A +: fcpm_pkg::PRE_W]),
      .pre_b_i(clkcfg[fcpm_pkg::F_PRE_B +: fcpm_pkg::PRE_W]),
      .scal0_i(scal[fcpm_pkg::F_SCAL0 +: 8]),
      .scal1_i(scal[fcpm_pkg::F_SCAL1 +: 8]),
      .scal0_load_i(wr && adr_i == fcpm_pkg::OFS_SCAL && sel_i[0]),
      .scal1_load_i(wr && adr_i == fcpm_pkg::OFS_SCAL && sel_i[1]),
      .tick_a_o(tick_a),
      .tick_b_o(tick_b),
      .tick_s0_o(tick_s0),
      .tick_s1_o(tick_s1)
   );

   // Channels that are the high half of a pair run as one 16-bit unit:
   // lower channel is the high byte, higher channel's clock is used.
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_ch
         logic joined;
         logic is_hi;
         logic [15:0] pb;
         logic [15:0] db;
         if (g % 2 == 0) begin : g_even
            assign joined = (g == 0) ? con_lo : con_hi;
            assign is_hi = joined;
         end else begin : g_odd
            assign joined = (g == 1) ? con_lo : con_hi;
            assign is_hi = 1'b0;
         end
         assign pb = is_hi ? {per_buf[g], per_buf[g+(g%2==0?1:0)]} : {8'h00, per_buf[g]};
         assign db = is_hi ? {duty_buf[g], duty_buf[g+(g%2==0?1:0)]} : {8'h00, duty_buf[g]};
         fcpm_chan #(.W(16)) u_ch (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .en_i(en[g] && !(joined && !is_hi)),
            .pol_i(pol[g]),
            .center_i(center[g]),
            .tick_i(is_hi ? tick_sel[g+(g%2==0?1:0)] : tick_sel[g]),
            .per_buf_i(pb),
            .duty_buf_i(db),
            .cnt_wr_i(cnt_wr[g] || (is_hi && cnt_wr[g+(g%2==0?1:0)])),
            .cnt_o(cnt16[g]),
            .per_o(per16[g]),
            .duty_o(duty16[g]),
            .wave_o(wave[g])
         );
         // Channel drives its pin only when enabled and not the absorbed half.
         assign chan_on[g] = en[g] && !(joined && !is_hi);
         // Counter write strobe for this channel's register.
         assign cnt_wr[g] = wr && adr_i == fcpm_pkg::OFS_CNT0 + 8'(g) * fcpm_pkg::OFS_STRIDE
                            && sel_i[0];
      end
   endgenerate

   // Enabled channel, unless it is the absorbed half of a pair, forces its pin as output; otherwise the port owns it.
   assign pin_drive = chan_on;
   assign pin_o = (pin_drive & wave) | (~pin_drive & port_out);
   assign pin_oe_o = pin_drive | port_dir;

   // Named register hits; the bank hits also need a word-aligned address.
   logic hit_ctrl;
   logic hit_clk;
   logic hit_scal;
   logic hit_pout;
   logic hit_pdir;
   logic hit_per;
   logic hit_duty;
   logic [1:0] widx;
   logic [31:0] ctrl_mrg;
   logic [31:0] clk_mrg;
   logic [31:0] scal_mrg;
   assign hit_ctrl = adr_i == fcpm_pkg::OFS_CTRL;
   assign hit_clk = adr_i == fcpm_pkg::OFS_CLK;
   assign hit_scal = adr_i == fcpm_pkg::OFS_SCAL;
   assign hit_pout = adr_i == fcpm_pkg::OFS_PORT_OUT;
   assign hit_pdir = adr_i == fcpm_pkg::OFS_PORT_DIR;
   assign hit_per = in_bank(adr_i, fcpm_pkg::OFS_PER0);
   assign hit_duty = in_bank(adr_i, fcpm_pkg::OFS_DUTY0);
   assign widx = adr_i[3:2];

   // Byte-merged next values; the write strobe decides whether they land.
   assign ctrl_mrg = merge({16'h0000, ctrl}, dat_i, sel_i);
   assign clk_mrg = merge({20'h00000, clkcfg}, dat_i, sel_i);
   assign scal_mrg = merge({16'h0000, scal}, dat_i, sel_i);

   // Control word; clearing it at reset hands every pin to the port.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= '0;
      end else if (wr && hit_ctrl) begin
         ctrl <= ctrl_mrg[15:0];
      end
   end

   // Clock selection and prescaler codes.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clkcfg <= '0;
      end else if (wr && hit_clk) begin
         clkcfg <= clk_mrg[11:0];
      end
   end

   // Scale values; the scaler itself reloads on the same strobe.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scal <= '0;
      end else if (wr && hit_scal) begin
         scal <= scal_mrg[15:0];
      end
   end

   // Port output value, shown only on pins no channel owns.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_out <= '0;
      end else if (wr && hit_pout && sel_i[0]) begin
         port_out <= dat_i[3:0];
      end
   end

   // Port direction; an enabled channel overrides it without changing it.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_dir <= '0;
      end else if (wr && hit_pdir && sel_i[0]) begin
         port_dir <= dat_i[3:0];
      end
   end

   // Buffers take any write with sel_i[0] set; latches follow inside the channel
   // according to its enable, so a live waveform is never torn.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < N; i++) begin
            per_buf[i] <= 8'h00;
            duty_buf[i] <= 8'h00;
         end
      end else if (wr && sel_i[0]) begin
         if (hit_per) per_buf[widx] <= dat_i[7:0];
         if (hit_duty) duty_buf[widx] <= dat_i[7:0];
      end
   end

   // Read mux; a paired channel reports its own byte of the 16-bit count.
   function automatic logic [7:0] cnt_byte(input int i, input logic joined);
      cnt_byte = 8'h00;
      if (joined && i % 2 == 0) cnt_byte = cnt16[i][15:8];
      else if (joined) cnt_byte = cnt16[i-1][7:0];
      else cnt_byte = cnt16[i][7:0];
   endfunction : cnt_byte

   always_comb begin
      next_dat = fcpm_pkg::READ_UNMAPPED;
      if (adr_i == fcpm_pkg::OFS_CTRL) begin
         next_dat = {16'h0000, ctrl};
      end else if (adr_i == fcpm_pkg::OFS_CLK) begin
         next_dat = {20'h00000, clkcfg};
      end else if (adr_i == fcpm_pkg::OFS_SCAL) begin
         next_dat = {16'h0000, scal};
      end else if (adr_i == fcpm_pkg::OFS_PORT_OUT) begin
         next_dat = {28'h0000000, port_out};
      end else if (adr_i == fcpm_pkg::OFS_PORT_DIR) begin
         next_dat = {28'h0000000, port_dir};
      end else if (adr_i == fcpm_pkg::OFS_PIN) begin
         next_dat = {28'h0000000, pin_i};
      end else if (in_bank(adr_i, fcpm_pkg::OFS_CNT0)) begin
         next_dat = {24'h000000, cnt_byte(int'(adr_i[3:2]),
                     adr_i[3] ? con_hi : con_lo)};
      end else if (in_bank(adr_i, fcpm_pkg::OFS_PER0)) begin
         next_dat = {24'h000000, per_buf[adr_i[3:2]]};
      end else if (in_bank(adr_i, fcpm_pkg::OFS_DUTY0)) begin
         next_dat = {24'h000000, duty_buf[adr_i[3:2]]};
      end
   end

   // One-cycle registered ack; unmapped reads return zero, writes drop.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= req;
         if (req && !we_i) dat_o <= next_dat;
      end
   end

   // 8-bit mode keeps upper bytes zero, so one 16-bit core serves both.
endmodule : fcpm_top
`default_nettype wire
